/* rtl/mdv_unit.sv */
// Multiply/divide unit running beside the integer pipeline.
// Assumes the integer pipeline holds an issued instruction while
// stall_out is high and reads accumulators via the read port.
// Contract
// RULE1: Operations advance in their own pipeline and never wait on it.
// RULE2: The multiplier takes two full 32-bit operands via booth recoding.
// RULE3: Four upper/lower result pairs receive multiply and divide results.
// RULE4: A new multiply may be accepted on every clock.
// RULE5: Divide resolves exactly one quotient bit per clock in an FSM.
// RULE6: Dividends fitting 8/16/24 bits skip 23/15/7 iterations.
// RULE7: Any issue during an active divide stalls the integer pipeline.
// RULE8: Multiplies have latency 5 and repeat rate 1.
// RULE9: Divide latency is 12/14, 20/22, 28/30, 36/38 by dividend width.
// RULE10: An accumulator index picks the pair; zero is the default.
`timescale 1ns/100ps
`default_nettype none
module mdv_unit
   import mdv_pkg::*;
(
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic issue_valid_in,
   input wire logic [2:0] op_in,
   input wire logic signed_in,
   input wire logic [1:0] acc_sel_in,
   input wire logic [31:0] first_source_operand_in,
   input wire logic [31:0] second_source_operand_in,
   input wire logic [1:0] acc_rd_sel_in,
   output logic stall_out,
   output logic div_busy_out,
   output logic gpr_valid_out,
   output logic [31:0] gpr_result_out,
   output logic [31:0] upper_result_half_out,
   output logic [31:0] lower_result_half_out
);

   ////////////////////////////////////////////////////////////////////////
   // Divide sizing: early-in skip and latency by width and variant
   function automatic logic [5:0] div_skip(input logic [31:0] mag);
      begin
         if (mag[31:8] == 24'h0) div_skip = SKIP_8;
         else if (mag[31:16] == 16'h0) div_skip = SKIP_16;
         else if (mag[31:24] == 8'h0) div_skip = SKIP_24;
         else div_skip = SKIP_32;
      end
   endfunction

   function automatic logic [5:0] div_lat(input logic [31:0] mag,
                                          input logic sgn);
      begin
         if (mag[31:8] == 24'h0) div_lat = sgn ? DIV_LAT_S8 : DIV_LAT_U8;
         else if (mag[31:16] == 16'h0)
            div_lat = sgn ? DIV_LAT_S16 : DIV_LAT_U16;
         else if (mag[31:24] == 8'h0)
            div_lat = sgn ? DIV_LAT_S24 : DIV_LAT_U24;
         else div_lat = sgn ? DIV_LAT_S32 : DIV_LAT_U32;
      end
   endfunction

   function automatic logic [31:0] neg_if(input logic [31:0] v,
                                          input logic n);
      begin
         neg_if = n ? (~v + 32'h1) : v;
      end
   endfunction

   mdv_div_state_e div_state_reg;
   logic [5:0] div_cnt_reg;
   logic [5:0] div_iter_reg;
   logic [31:0] div_quo_reg;
   logic [31:0] div_rem_reg;
   logic [31:0] div_dsr_reg;
   logic div_negq_reg;
   logic div_negr_reg;
   logic [1:0] div_acc_reg;
   logic div_busy;
   logic div_done;
   logic issue_ok;
   logic mul_issue;
   logic div_issue;
   logic [31:0] a_mag;
   logic [31:0] b_mag;
   logic [32:0] rem_sh;
   logic [33:0] trial;

   logic s1_vld_reg;
   mdv_op_e s1_op_reg;
   logic [1:0] s1_acc_reg;
   logic [31:0] s1_a_reg;
   logic [31:0] s1_b_reg;
   logic s1_sgn_reg;
   logic [63:0] product;
   logic p_vld_reg [2:4];
   mdv_op_e p_op_reg [2:4];
   logic [1:0] p_acc_reg [2:4];
   logic [63:0] p_prod_reg [2:4];
   logic [63:0] acc_reg [0:ACC_PAIRS-1];
   logic [63:0] wb_val;

   ////////////////////////////////////////////////////////////////////////
   // Issue and stall; the unit has no stall input so it always advances
   assign div_busy = (div_state_reg != DIV_IDLE);
   assign issue_ok = issue_valid_in & ~div_busy;
   assign stall_out = issue_valid_in & div_busy; // [RULE7]
   assign div_busy_out = div_busy;
   assign mul_issue = issue_ok & (op_in >= 3'h1) & (op_in <= 3'h4); // [RULE4]
   assign div_issue = issue_ok & (op_in == OP_QUOTIENT_REMAINDER);

   // Stage 1 captures operands on any clock a multiply is offered
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         s1_vld_reg <= 1'b0;
         s1_op_reg <= OP_NONE;
         s1_acc_reg <= 2'h0;
         s1_a_reg <= WORD_RST;
         s1_b_reg <= WORD_RST;
         s1_sgn_reg <= 1'b0;
      end
      else
      begin
         s1_vld_reg <= mul_issue; // [RULE1]
         s1_op_reg <= mdv_op_e'(op_in);
         s1_acc_reg <= acc_sel_in; // [RULE10]
         s1_a_reg <= first_source_operand_in;
         s1_b_reg <= second_source_operand_in;
         s1_sgn_reg <= signed_in;
      end
   end

   mdv_booth_mul u_mul
   (
      .first_source_operand_in(s1_a_reg),
      .second_source_operand_in(s1_b_reg),
      .signed_in(s1_sgn_reg),
      .product_out(product)
   );

   // Stages 2..4 carry the product; write-back lands on the fifth edge
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         for (int i = 2; i <= 4; i++)
         begin
            p_vld_reg[i] <= 1'b0;
            p_op_reg[i] <= OP_NONE;
            p_acc_reg[i] <= 2'h0;
            p_prod_reg[i] <= ACC_RST;
         end
      end
      else
      begin
         p_vld_reg[2] <= s1_vld_reg;
         p_op_reg[2] <= s1_op_reg;
         p_acc_reg[2] <= s1_acc_reg;
         p_prod_reg[2] <= product; // [RULE2]
         for (int i = 3; i <= 4; i++)
         begin
            p_vld_reg[i] <= p_vld_reg[i-1]; // [RULE8]
            p_op_reg[i] <= p_op_reg[i-1];
            p_acc_reg[i] <= p_acc_reg[i-1];
            p_prod_reg[i] <= p_prod_reg[i-1];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Accumulator pairs; writes stay in issue order so back-to-back
   // accumulates see each other without forwarding
   always_comb
   begin
      case (p_op_reg[4])
         OP_PRODUCT_ACCUMULATE_ADD:
            wb_val = acc_reg[p_acc_reg[4]] + p_prod_reg[4];
         OP_PRODUCT_ACCUMULATE_SUBTRACT:
            wb_val = acc_reg[p_acc_reg[4]] - p_prod_reg[4];
         default: wb_val = p_prod_reg[4];
      endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         for (int i = 0; i < ACC_PAIRS; i++)
         begin
            acc_reg[i] <= ACC_RST;
         end
      end
      else
      begin
         if (p_vld_reg[4] && (p_op_reg[4] != OP_MUL_GPR))
         begin
            acc_reg[p_acc_reg[4]] <= wb_val; // [RULE3] [RULE8]
         end
         if (div_done)
         begin
            acc_reg[div_acc_reg] <= {neg_if(div_rem_reg, div_negr_reg),
                                     neg_if(div_quo_reg, div_negq_reg)}; // [RULE3]
         end
      end
   end

   // Register-file result and accumulator read port
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         gpr_valid_out <= 1'b0;
         gpr_result_out <= WORD_RST;
         upper_result_half_out <= WORD_RST;
         lower_result_half_out <= WORD_RST;
      end
      else
      begin
         gpr_valid_out <= p_vld_reg[4] & (p_op_reg[4] == OP_MUL_GPR); // [RULE8]
         if (p_vld_reg[4] && (p_op_reg[4] == OP_MUL_GPR))
         begin
            gpr_result_out <= p_prod_reg[4][31:0];
         end
         upper_result_half_out <= acc_reg[acc_rd_sel_in][63:32];
         lower_result_half_out <= acc_reg[acc_rd_sel_in][31:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Restoring divide on magnitudes, one bit per clock; the countdown
   // pads the run so the answer lands exactly at the tabled latency
   assign a_mag = neg_if(first_source_operand_in,
                         signed_in & first_source_operand_in[31]);
   assign b_mag = neg_if(second_source_operand_in,
                         signed_in & second_source_operand_in[31]);
   assign rem_sh = {div_rem_reg, div_quo_reg[31]};
   assign trial = {1'b0, rem_sh} - {2'h0, div_dsr_reg};
   assign div_done = (div_state_reg == DIV_WAIT) && (div_cnt_reg == 6'h1);

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         div_state_reg <= DIV_IDLE;
         div_cnt_reg <= 6'h0;
         div_iter_reg <= 6'h0;
         div_quo_reg <= WORD_RST;
         div_rem_reg <= WORD_RST;
         div_dsr_reg <= WORD_RST;
         div_negq_reg <= 1'b0;
         div_negr_reg <= 1'b0;
         div_acc_reg <= 2'h0;
      end
      else
      begin
         case (div_state_reg)
            DIV_IDLE:
            begin
               if (div_issue)
               begin
                  div_state_reg <= DIV_ITER;
                  div_cnt_reg <= div_lat(a_mag, signed_in) - 6'h1; // [RULE9]
                  div_iter_reg <= FULL_ITER - div_skip(a_mag); // [RULE6]
                  div_quo_reg <= a_mag << div_skip(a_mag); // [RULE6]
                  div_rem_reg <= WORD_RST;
                  div_dsr_reg <= b_mag;
                  div_negq_reg <= signed_in & (first_source_operand_in[31]
                                  ^ second_source_operand_in[31]);
                  div_negr_reg <= signed_in & first_source_operand_in[31];
                  div_acc_reg <= acc_sel_in; // [RULE10]
               end
            end
            DIV_ITER:
            begin
               div_cnt_reg <= div_cnt_reg - 6'h1;
               div_iter_reg <= div_iter_reg - 6'h1; // [RULE5]
               div_quo_reg <= {div_quo_reg[30:0], ~trial[33]};
               div_rem_reg <= trial[33] ? rem_sh[31:0] : trial[31:0];
               if (div_iter_reg == 6'h1)
               begin
                  div_state_reg <= DIV_WAIT;
               end
            end
            DIV_WAIT:
            begin
               div_cnt_reg <= div_cnt_reg - 6'h1;
               if (div_cnt_reg == 6'h1)
               begin
                  div_state_reg <= DIV_IDLE; // [RULE9]
               end
            end
            default: div_state_reg <= DIV_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks; helper counter times each divide from its issue edge
   logic [5:0] chk_cnt_reg;
   logic [5:0] chk_exp_reg;
   logic [31:0] mul_ref;
   logic gpr_issue;
   assign mul_ref = first_source_operand_in * second_source_operand_in;
   assign gpr_issue = mul_issue & (op_in == OP_MUL_GPR);

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         chk_cnt_reg <= 6'h0;
         chk_exp_reg <= 6'h0;
      end
      else if (div_issue)
      begin
         chk_cnt_reg <= 6'h1;
         chk_exp_reg <= div_lat(a_mag, signed_in);
      end
      else if (div_busy)
      begin
         chk_cnt_reg <= chk_cnt_reg + 6'h1;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   stall_on_busy_a: assert property (issue_valid_in && div_busy // [RULE7]
      |-> stall_out ##1 !s1_vld_reg)
      else $error("issue during divide not stalled");
   // Back-to-back results may overlap the issue, so no idle pulse is demanded
   mul_latency_a: assert property (gpr_issue |-> ##5 gpr_valid_out) // [RULE8]
      else $error("multiply result not at latency five");
   gpr_pulse_src_a: assert property (gpr_valid_out // [RULE8]
      |-> $past(gpr_issue, 5))
      else $error("result pulse without a multiply five clocks back");
   mul_product_a: assert property (gpr_valid_out // [RULE2]
      |-> gpr_result_out == $past(mul_ref, 5))
      else $error("multiply product wrong");
   mul_repeat_a: assert property (mul_issue ##1 mul_issue // [RULE4]
      |-> ##3 p_vld_reg[4] ##1 p_vld_reg[4])
      else $error("back to back multiply lost");
   pipe_advance_a: assert property (s1_vld_reg |=> p_vld_reg[2] ##1 // [RULE1]
      p_vld_reg[3])
      else $error("multiply pipeline did not advance");
   acc_select_a: assert property (mul_issue && op_in == OP_PRODUCT_INTO_ACC // [RULE10]
      |-> ##5 acc_reg[$past(acc_sel_in, 5)][31:0] == $past(mul_ref, 5))
      else $error("product not in selected pair");
   div_skip_a: assert property (div_issue && a_mag[31:8] == 24'h0 // [RULE6]
      |=> div_iter_reg == 6'h9)
      else $error("eight-bit dividend skip wrong");
   div_bit_a: assert property (div_state_reg == DIV_ITER && div_iter_reg > 6'h1 // [RULE5]
      |=> div_state_reg == DIV_ITER && div_iter_reg == $past(div_iter_reg) - 6'h1)
      else $error("divide not one bit per clock");
   div_latency_a: assert property (div_done |-> chk_cnt_reg == chk_exp_reg - 6'h1) // [RULE9]
      else $error("divide latency wrong");
   div_result_a: assert property (div_done && !div_negq_reg && !div_negr_reg // [RULE3]
      && div_dsr_reg != 32'h0 |=> acc_reg[$past(div_acc_reg)][63:32]
      < $past(div_dsr_reg))
      else $error("divide remainder out of range");

   cov_mac_c: cover property (mul_issue && op_in == OP_PRODUCT_ACCUMULATE_ADD
      ##1 mul_issue && op_in == OP_PRODUCT_ACCUMULATE_SUBTRACT);
   cov_div_c: cover property (div_issue && signed_in ##1 div_busy [*3]);
   cov_stall_c: cover property (stall_out ##1 stall_out);
   cov_done_c: cover property (div_done ##1 mul_issue);
endmodule
`default_nettype wire

/* rtl/mdv_pkg.sv */
// Constants, opcodes and state codes shared by the multiply/divide unit.
// Assumes a single 10 MHz pipeline clock; no software-visible registers.
package mdv_pkg;
   localparam int DATA_W = 32;
   localparam int ACC_PAIRS = 4;
   localparam logic [63:0] ACC_RST = 64'h0;
   localparam logic [31:0] WORD_RST = 32'h0;
   // Pipeline timing in clocks (10 MHz, 100 ns)
   localparam int CLK_PERIOD_NS = 100;
   localparam int MUL_LATENCY = 5;
   localparam int MUL_REPEAT = 1;
   // Early-in skip counts by dividend width
   localparam logic [5:0] SKIP_8 = 6'h17;
   localparam logic [5:0] SKIP_16 = 6'h0F;
   localparam logic [5:0] SKIP_24 = 6'h07;
   localparam logic [5:0] SKIP_32 = 6'h00;
   localparam logic [5:0] FULL_ITER = 6'h20;
   // Divide latency = repeat rate; unsigned / signed variant
   localparam logic [5:0] DIV_LAT_U8 = 6'h0C;
   localparam logic [5:0] DIV_LAT_S8 = 6'h0E;
   localparam logic [5:0] DIV_LAT_U16 = 6'h14;
   localparam logic [5:0] DIV_LAT_S16 = 6'h16;
   localparam logic [5:0] DIV_LAT_U24 = 6'h1C;
   localparam logic [5:0] DIV_LAT_S24 = 6'h1E;
   localparam logic [5:0] DIV_LAT_U32 = 6'h24;
   localparam logic [5:0] DIV_LAT_S32 = 6'h26;

   typedef enum logic [2:0]
   {
      OP_NONE = 3'h0,
      OP_PRODUCT_INTO_ACC = 3'h1,
      OP_PRODUCT_ACCUMULATE_ADD = 3'h2,
      OP_PRODUCT_ACCUMULATE_SUBTRACT = 3'h3,
      OP_MUL_GPR = 3'h4,
      OP_QUOTIENT_REMAINDER = 3'h5
   } mdv_op_e;

   typedef enum logic [1:0]
   {
      DIV_IDLE = 2'h0,
      DIV_ITER = 2'h1,
      DIV_WAIT = 2'h2
   } mdv_div_state_e;
endpackage

/* rtl/mdv_booth_mul.sv */
// Combinational radix-4 booth recoded 32x32 multiplier.
// Assumes the caller registers the product; signed_in selects two's
// complement or unsigned view of both operands.
`timescale 1ns/100ps
`default_nettype none
module mdv_booth_mul
   import mdv_pkg::*;
(
   input wire logic [31:0] first_source_operand_in,
   input wire logic [31:0] second_source_operand_in,
   input wire logic signed_in,
   output logic [63:0] product_out
);

   ////////////////////////////////////////////////////////////////////////
   // One partial product per three-bit overlapping group
   function automatic logic [65:0] booth_pp(input logic [2:0] grp,
                                            input logic [65:0] mcand);
      logic [65:0] pp;
      begin
         case (grp)
            3'h1, 3'h2: pp = mcand;
            3'h3: pp = mcand << 1;
            3'h4: pp = ~(mcand << 1) + 66'h1;
            3'h5, 3'h6: pp = ~mcand + 66'h1;
            default: pp = 66'h0;
         endcase
         booth_pp = pp;
      end
   endfunction

   logic [65:0] mcand_x;
   logic [34:0] mplier_x;
   logic [65:0] sum;
   logic ext_a;
   logic ext_b;

   // Operands widened so unsigned values survive the signed recoding
   assign ext_a = signed_in & first_source_operand_in[31];
   assign ext_b = signed_in & second_source_operand_in[31];
   assign mcand_x = {{34{ext_a}}, first_source_operand_in};
   assign mplier_x = {ext_b, ext_b, second_source_operand_in, 1'b0};

   // Seventeen groups cover the 34-bit widened multiplier
   always_comb
   begin
      sum = 66'h0;
      for (int i = 0; i < 17; i++)
      begin
         sum = sum + (booth_pp(mplier_x[2*i +: 3], mcand_x) << (2*i)); // [RULE2]
      end
   end

   assign product_out = sum[63:0];
endmodule
`default_nettype wire

/* sim/mdv_pipe_model.sv */
// Integer pipeline model that issues work to the multiply/divide unit.
// Assumes a rising-edge clock; it drives its signals at the falling edge.
`timescale 1ns/100ps
`default_nettype none
module mdv_pipe_model
(
   input wire logic clk_in,
   input wire logic stall_in,
   output logic valid_out,
   output logic [2:0] op_out,
   output logic sgn_out,
   output logic [1:0] acc_out,
   output logic [31:0] a_out,
   output logic [31:0] b_out
);
   int cyc = 0;
   int seed = 35;
   ////////////////////////////////////////////////////////////////////////
   // Cycle count as seen by the issuing side
   always @(posedge clk_in)
      cyc <= cyc + 1;
   // Offer one instruction and hold it while the unit stalls us
   task automatic issue(input logic [2:0] op, input logic sgn,
      input logic [1:0] acc, input logic [31:0] a, input logic [31:0] b,
      output int taken);
      @(negedge clk_in);
      valid_out = 1'b1;
      op_out = op;
      sgn_out = sgn;
      acc_out = acc;
      a_out = a;
      b_out = b;
      #1;
      while (stall_in !== 1'b0)
      begin
         @(negedge clk_in);
         #1;
      end
      taken = cyc;
   endtask
   // Released fields carry noise, so a stale value can never pass
   task automatic idle(input int n);
      repeat (n)
      begin
         @(negedge clk_in);
         valid_out = 1'b0;
         op_out = 3'($random(seed));
         sgn_out = 1'($random(seed));
         acc_out = 2'($random(seed));
         a_out = $random(seed);
         b_out = $random(seed);
      end
   endtask
   // Quiet outputs at time zero
   initial
   begin
      valid_out = 1'b0;
      op_out = 3'h0;
      sgn_out = 1'b0;
      acc_out = 2'h0;
      a_out = 32'h0;
      b_out = 32'h0;
   end
endmodule
`default_nettype wire

/* sim/mdv_unit_tb.sv */
// Self-checking bench for the multiply/divide unit.
// Assumes the pipeline model in sim/ and the unit's package constants.
`timescale 1ns/100ps
`default_nettype none
module mdv_unit_tb
   import mdv_pkg::*;
   ;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [1:0] rd_sel = 2'h0;
   logic iv, sg, stall, busy, gv;
   logic [2:0] op;
   logic [1:0] acs;
   logic [31:0] opa, opb, gr, up, low_half;
   int num_errors = 0;
   int samples_checked = 0;
   int cyc = 0;
   int seed = 35;
   logic [63:0] acc_m [4] = '{default: 64'h0};
   int due_q[$];
   logic [31:0] val_q[$];
   // Accumulate forms plus ignored codes, and one dividend per width
   logic [2:0] ops [6] = '{3'h1, 3'h2, 3'h3, 3'h6, 3'h7, 3'h0};
   logic [31:0] dvd [4] = '{32'd100, 32'd30000, 32'd5000000,
      32'h70000000};
   ////////////////////////////////////////////////////////////////////////
   // Design and its issuing partner
   mdv_unit u_mdv_unit (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .issue_valid_in(iv), .op_in(op), .signed_in(sg), .acc_sel_in(acs),
      .first_source_operand_in(opa), .second_source_operand_in(opb),
      .acc_rd_sel_in(rd_sel), .stall_out(stall), .div_busy_out(busy),
      .gpr_valid_out(gv), .gpr_result_out(gr),
      .upper_result_half_out(up), .lower_result_half_out(low_half));
   mdv_pipe_model u_mdv_pipe_model (.clk_in(clk_in), .stall_in(stall),
      .valid_out(iv), .op_out(op), .sgn_out(sg), .acc_out(acs),
      .a_out(opa), .b_out(opb));
   ////////////////////////////////////////////////////////////////////////
   // Clock and cycle count
   initial
      forever #50 clk_in = ~clk_in;
   always @(posedge clk_in)
      cyc <= cyc + 1;
   // Compare and count
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      $display("Checks %0d, errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Reference arithmetic, full 64-bit product in both views
   function automatic logic [63:0] prod(input logic s, input logic [31:0] a,
      input logic [31:0] b);
      longint x, y;
      x = s ? longint'($signed(a)) : longint'(a);
      y = s ? longint'($signed(b)) : longint'(b);
      return 64'(x * y);
   endfunction
   function automatic logic [63:0] divm(input logic s, input logic [31:0] a,
      input logic [31:0] b);
      longint x, y;
      x = s ? longint'($signed(a)) : longint'(a);
      y = s ? longint'($signed(b)) : longint'(b);
      return {32'(x % y), 32'(x / y)};
   endfunction
   // Issue through the partner and update the reference model
   task automatic do_op(input logic [2:0] o, input logic s,
      input logic [1:0] k, input logic [31:0] a, input logic [31:0] b,
      output int t);
      logic [63:0] p;
      u_mdv_pipe_model.issue(o, s, k, a, b, t);
      p = prod(s, a, b);
      case (o)
         3'h1: acc_m[k] = p;
         3'h2: acc_m[k] = acc_m[k] + p;
         3'h3: acc_m[k] = acc_m[k] - p;
         3'h4:
         begin
            due_q.push_back(t + MUL_LATENCY);
            val_q.push_back(p[31:0]);
         end
         3'h5: acc_m[k] = divm(s, a, b);
         default: ;
      endcase
   endtask
   // Read port answers one cycle after the select
   task automatic read_acc(input logic [1:0] k);
      @(negedge clk_in);
      rd_sel = k;
      @(negedge clk_in);
      check({up, low_half}, acc_m[k]);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Result pulse must land exactly on its due cycle, never elsewhere
   always @(negedge clk_in)
      if (!sys_rst_in)
      begin
         if (due_q.size() > 0 && due_q[0] == cyc)
         begin
            check(gv, 1'b1);
            check(gr, val_q[0]);
            void'(due_q.pop_front());
            void'(val_q.pop_front());
         end
         else
            check(gv, 1'b0);
      end
   // Watchdog, far beyond the expected run of under a thousand cycles
   initial
   begin
      #(100 * 5000);
      num_errors++;
      wrap_up();
   end
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      int t0, t1;
      logic [31:0] dv;
      repeat (3) @(negedge clk_in);
      sys_rst_in = 1'b0;
      for (int k = 0; k < 4; k++)
         read_acc(2'(k));
      // Back-to-back random multiplies into the general result
      for (int i = 0; i < 40; i++)
         do_op(3'h4, 1'($random(seed)), 2'h0, $random(seed),
            (i % 2) ? 32'($signed(16'($random(seed)))) : $random(seed), t0);
      u_mdv_pipe_model.idle(8);
      // Every accumulate form and the ignored codes, chained per pair
      for (int k = 0; k < 4; k++)
         for (int i = 0; i < 6; i++)
            do_op(ops[i], 1'($random(seed)), 2'(k), $random(seed),
               $random(seed), t0);
      u_mdv_pipe_model.idle(7);
      for (int k = 0; k < 4; k++)
         read_acc(2'(k));
      // Each dividend width in both variants, with a stalled follower
      for (int s = 0; s < 2; s++)
         for (int w = 0; w < 4; w++)
         begin
            dv = (s == 1 && w % 2 == 1) ? -dvd[w] : dvd[w];
            do_op(3'h4, 1'b0, 2'h0, $random(seed), $random(seed), t0);
            do_op(3'h5, 1'(s), 2'(w), dv, s ? -32'sd7 : 32'd7, t0);
            // Divide held open: busy shows and the held issue is stalled
            @(negedge clk_in);
            check(busy, 1'b1);
            check(stall, 1'b1);
            do_op(3'h4, 1'b1, 2'h0, $random(seed), $random(seed), t1);
            check(t1 - t0, 12 + 8 * w + 2 * s);
            check(busy, 1'b0);
            u_mdv_pipe_model.idle(8);
            read_acc(2'(w));
         end
      // Reset in mid-divide must free the unit and clear every pair
      do_op(3'h5, 1'b0, 2'h3, dvd[3], 32'd7, t0);
      u_mdv_pipe_model.idle(3);
      sys_rst_in = 1'b1;
      acc_m = '{default: 64'h0};
      u_mdv_pipe_model.idle(2);
      sys_rst_in = 1'b0;
      check(busy, 1'b0);
      for (int k = 0; k < 4; k++)
         read_acc(2'(k));
      u_mdv_pipe_model.idle(4);
      wrap_up();
   end
endmodule
`default_nettype wire
